// >>> core/fws_host.sv
// module: apb controlled host that issues flash commands and polls status bits
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/100ps

// Behaviour
// - host reads poll bit at the programmed address
// - host reads erase poll status inside a selected sector
// - after poll bit turns true, host takes full data on later read
// - host rereads poll bit after limit bit is seen high
// - host reads twice, compares toggle bit; unchanged means done
// - still toggling: check limit bit, retest; still toggling means fail, reset
// - host resuming polling restarts with the double read; here only the first round does, later rounds compare with the previous read
// - after limit failure host issues reset command
// - host may ignore window bit only under 50 us command spacing
// - host confirms acceptance, checks window bit before and after added sector
// - window lasts 50 us; other commands in window return to array reads
// - reset command is AA to 5555, 55 to 2AAA, F0 to 5555
module fws_host (
    // clock and reset
    input  wire logic                core_clk_i,
    input  wire logic                reset_n_i,
    // apb slave
    input  wire logic                psel_i,
    input  wire logic                penable_i,
    input  wire logic                pwrite_i,
    input  wire logic [7:0]          paddr_i,
    input  wire logic [31:0]         pwdata_i,
    output fws_pkg::fws_apb_rsp_t    apb_o,
    // flash pins
    output fws_pkg::fws_pins_t       flash_o,
    input  wire logic [7:0]          data_lines_i
);

    typedef enum logic [3:0] {
        H_IDLE, H_SEQ, H_POLL1, H_POLL2, H_RECHK, H_FINAL, H_WCHK_PRE, H_WCHK_POST
    } fws_hst_t;

    typedef struct packed {
        fws_hst_t       st;
        logic [2:0]     cmd;
        logic [2:0]     step;      // command cycle index
        logic [16:0]    addr;
        logic [7:0]     data;
        logic [7:0]     width;
        logic           busy;
        logic           done;
        logic           fail;
        logic           window;
        logic           drop;
        logic           pend;      // bus cycle in flight
        logic           limit_seen;
        logic [7:0]     first;     // first read of a pair
        fws_pkg::fws_apb_rsp_t apb;
    } fws_host_t;

    fws_host_t    s_q;
    fws_host_t    s_d;
    logic         bc_start;
    logic         bc_write;
    logic [16:0]  bc_addr;
    logic [7:0]   bc_wdata;
    logic         bc_done;
    logic [7:0]   bc_rdata;
    logic         cyc_last;
    logic [16:0]  seq_addr;
    logic [7:0]   seq_data;
    logic [2:0]   seq_len;
    logic         apb_acc;

    // --------------------------------------------------------------
    // command sequence tables
    // --------------------------------------------------------------

    // address and data of each write cycle of the current command
    always_comb begin
        seq_addr = fws_pkg::UNLOCK_ADDR1;
        seq_data = fws_pkg::UNLOCK_DATA1;
        seq_len  = 3'd6;
        case (s_q.cmd)
            fws_pkg::CMD_RESET:  seq_len = 3'd3;
            fws_pkg::CMD_PROG:   seq_len = 3'd4;
            fws_pkg::CMD_ADDSEC: seq_len = 3'd1;
            default:             seq_len = 3'd6;
        endcase
        if (s_q.cmd == fws_pkg::CMD_ADDSEC) begin
            // added sector is the sector erase last cycle alone
            seq_addr = s_q.addr;
            seq_data = fws_pkg::CODE_SECT;
        end else begin
            case (s_q.step)
                3'd0: begin
                    seq_addr = fws_pkg::UNLOCK_ADDR1;
                    seq_data = fws_pkg::UNLOCK_DATA1;
                end
                3'd1, 3'd4: begin
                    seq_addr = fws_pkg::UNLOCK_ADDR2;
                    seq_data = fws_pkg::UNLOCK_DATA2;
                end
                3'd2: begin
                    seq_addr = fws_pkg::UNLOCK_ADDR1;
                    if (s_q.cmd == fws_pkg::CMD_RESET) begin
                        seq_data = fws_pkg::CODE_RESET;
                    end else if (s_q.cmd == fws_pkg::CMD_PROG) begin
                        seq_data = fws_pkg::CODE_PROG;
                    end else begin
                        seq_data = fws_pkg::CODE_ESETUP;
                    end
                end
                3'd3: begin
                    if (s_q.cmd == fws_pkg::CMD_PROG) begin
                        seq_addr = s_q.addr;
                        seq_data = s_q.data;
                    end else begin
                        seq_addr = fws_pkg::UNLOCK_ADDR1;
                        seq_data = fws_pkg::UNLOCK_DATA1;
                    end
                end
                3'd5: begin
                    if (s_q.cmd == fws_pkg::CMD_CHIP) begin
                        seq_addr = fws_pkg::UNLOCK_ADDR1;
                        seq_data = fws_pkg::CODE_CHIP;
                    end else begin
                        seq_addr = s_q.addr;
                        seq_data = fws_pkg::CODE_SECT;
                    end
                end
                default: begin
                    seq_addr = fws_pkg::UNLOCK_ADDR1;
                    seq_data = fws_pkg::UNLOCK_DATA1;
                end
            endcase
        end
    end

    assign cyc_last = (s_q.step == seq_len - 3'd1);
    assign apb_acc  = psel_i & penable_i & ~s_q.apb.pready;

    // --------------------------------------------------------------
    // sequencer and apb register file
    // --------------------------------------------------------------

    // next state of the whole host
    always_comb begin
        s_d            = s_q;
        s_d.apb.pready = 1'b0;
        bc_start       = 1'b0;
        bc_write       = 1'b0;
        // status reads at programmed or selected sector address
        bc_addr        = s_q.addr;
        bc_wdata       = seq_data;
        // apb access: one wait state, answer from a flop
        if (apb_acc) begin
            s_d.apb.pready  = 1'b1;
            s_d.apb.pslverr = 1'b0;
            s_d.apb.prdata  = 32'h0000_0000;
            case (paddr_i)
                fws_pkg::REG_CTRL: begin
                    if (pwrite_i && !s_q.busy && pwdata_i[2:0] != fws_pkg::CMD_NONE) begin
                        s_d.cmd  = pwdata_i[2:0];
                        s_d.step = 3'd0;
                        s_d.busy = 1'b1;
                        s_d.done = 1'b0;
                        s_d.fail = 1'b0;
                        s_d.drop = 1'b0;
                        s_d.limit_seen = 1'b0;
                        // added sector checks window before its write
                        if (pwdata_i[2:0] == fws_pkg::CMD_ADDSEC) begin
                            s_d.st = H_WCHK_PRE;
                        end else if (pwdata_i[2:0] == fws_pkg::CMD_READ) begin
                            s_d.st = H_FINAL;
                        end else begin
                            s_d.st = H_SEQ;
                        end
                    end
                end
                fws_pkg::REG_ADDR: begin
                    if (pwrite_i && !s_q.busy) begin
                        s_d.addr = pwdata_i[16:0];
                    end
                    s_d.apb.prdata = {15'h0000, s_q.addr};
                end
                fws_pkg::REG_DATA: begin
                    if (pwrite_i && !s_q.busy) begin
                        s_d.data = pwdata_i[7:0];
                    end
                    s_d.apb.prdata = {24'h00_0000, s_q.data};
                end
                fws_pkg::REG_STATUS: begin
                    s_d.apb.prdata[fws_pkg::ST_BUSY]   = s_q.busy;
                    s_d.apb.prdata[fws_pkg::ST_DONE]   = s_q.done;
                    s_d.apb.prdata[fws_pkg::ST_FAIL]   = s_q.fail;
                    s_d.apb.prdata[fws_pkg::ST_WINDOW] = s_q.window;
                    s_d.apb.prdata[fws_pkg::ST_DROP]   = s_q.drop;
                end
                fws_pkg::REG_TIMING: begin
                    if (pwrite_i && !s_q.busy) begin
                        s_d.width = pwdata_i[7:0];
                    end
                    s_d.apb.prdata = {24'h00_0000, s_q.width};
                end
                default: s_d.apb.pslverr = 1'b1;
            endcase
        end
        // flash side
        case (s_q.st)
            H_IDLE: begin
            end
            H_SEQ: begin
                bc_start = ~s_q.pend;
                bc_write = 1'b1;
                bc_addr  = seq_addr;
                s_d.pend = 1'b1;
                if (bc_done) begin
                    s_d.pend = 1'b0;
                    s_d.step = s_q.step + 3'd1;
                    if (cyc_last) begin
                        // polling starts only after the last strobe rose
                        if (s_q.cmd == fws_pkg::CMD_RESET) begin
                            s_d.st   = H_IDLE;
                            s_d.busy = 1'b0;
                            s_d.done = 1'b1;
                        end else if (s_q.cmd == fws_pkg::CMD_ADDSEC) begin
                            s_d.st = H_WCHK_POST;
                        end else begin
                            s_d.st = H_POLL1;
                        end
                    end
                end
            end
            H_WCHK_PRE, H_WCHK_POST, H_POLL1, H_POLL2, H_RECHK, H_FINAL: begin
                bc_start = ~s_q.pend;
                s_d.pend = 1'b1;
                if (bc_done) begin
                    s_d.pend = 1'b0;
                    s_d.first = bc_rdata;
                    case (s_q.st)
                        H_WCHK_PRE: begin
                            // window read, never timed: closed drops
                            s_d.window = bc_rdata[fws_pkg::WINDOW_BIT];
                            if (bc_rdata[fws_pkg::WINDOW_BIT]) begin
                                s_d.drop = 1'b1;
                                s_d.busy = 1'b0;
                                s_d.st   = H_IDLE;
                            end else begin
                                s_d.st = H_SEQ;
                            end
                        end
                        H_WCHK_POST: begin
                            // high after the write: sector may be lost
                            s_d.window = bc_rdata[fws_pkg::WINDOW_BIT];
                            s_d.drop   = bc_rdata[fws_pkg::WINDOW_BIT];
                            s_d.busy   = 1'b0;
                            s_d.st     = H_IDLE;
                        end
                        H_POLL1: begin
                            // only the first poll round begins with a fresh double read; later rounds compare with the previous read
                            s_d.st = H_POLL2;
                        end
                        H_POLL2, H_RECHK: begin
                            s_d.window = bc_rdata[fws_pkg::WINDOW_BIT];
                            // compare toggle bit of two consecutive reads
                            if (bc_rdata[fws_pkg::TOGGLE_BIT] ==
                                s_q.first[fws_pkg::TOGGLE_BIT]) begin
                                s_d.st = H_FINAL;
                            end else if (s_q.st == H_RECHK) begin
                                // still toggling after limit: failure, reset
                                s_d.fail = 1'b1;
                                s_d.cmd  = fws_pkg::CMD_RESET;
                                s_d.step = 3'd0;
                                s_d.st   = H_SEQ;
                            end else if (bc_rdata[fws_pkg::LIMIT_BIT]) begin
                                s_d.limit_seen = 1'b1;
                                s_d.st         = H_RECHK;
                            end else begin
                                s_d.st = H_POLL2;
                            end
                        end
                        H_FINAL: begin
                            // array data taken on a read after completion
                            s_d.data = bc_rdata;
                            s_d.busy = 1'b0;
                            s_d.done = 1'b1;
                            s_d.st   = H_IDLE;
                        end
                        default: s_d.st = H_IDLE;
                    endcase
                end
            end
            default: s_d.st = H_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_q       <= '0;
            s_q.st    <= H_IDLE;
            s_q.width <= fws_pkg::STROBE_CYC_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // --------------------------------------------------------------
    // pin cycle engine
    // --------------------------------------------------------------

    fws_bus_cycle u_cycle (
        .core_clk_i   (core_clk_i),
        .reset_n_i    (reset_n_i),
        .start_i      (bc_start),
        .write_i      (bc_write),
        .addr_i       (bc_addr),
        .wdata_i      (bc_wdata),
        .width_i      (s_q.width),
        .done_o       (bc_done),
        .rdata_o      (bc_rdata),
        .pins_o       (flash_o),
        .data_lines_i (data_lines_i)
    );

    assign apb_o = s_q.apb;

endmodule

// >>> inc/fws_pkg.sv
// package: register map, pin bundles, command codes and timing for the flash status host
package fws_pkg;

    // ------------------------------------------------------------
    // register map (apb byte offsets)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL   = 8'h00; // w: start command
    localparam logic [7:0] REG_ADDR   = 8'h04; // rw: target address
    localparam logic [7:0] REG_DATA   = 8'h08; // rw: program data / last read data
    localparam logic [7:0] REG_STATUS = 8'h0C; // r: controller status
    localparam logic [7:0] REG_TIMING = 8'h10; // rw: strobe width in cycles, minus one

    // ctrl command field values
    localparam logic [2:0] CMD_NONE   = 3'h0;
    localparam logic [2:0] CMD_PROG   = 3'h1;
    localparam logic [2:0] CMD_CHIP   = 3'h2;
    localparam logic [2:0] CMD_SECT   = 3'h3;
    localparam logic [2:0] CMD_RESET  = 3'h4;
    localparam logic [2:0] CMD_READ   = 3'h5;
    localparam logic [2:0] CMD_ADDSEC = 3'h6; // extra sector in window

    // status field positions
    localparam int ST_BUSY   = 0;
    localparam int ST_DONE   = 1;
    localparam int ST_FAIL   = 2;
    localparam int ST_WINDOW = 3; // last sampled erase window bit
    localparam int ST_DROP   = 4; // added sector may have been dropped

    // data line bit positions
    localparam int POLL_BIT   = 7;
    localparam int TOGGLE_BIT = 6;
    localparam int LIMIT_BIT  = 5;
    localparam int WINDOW_BIT = 3;

    // ------------------------------------------------------------
    // flash command cycles
    // ------------------------------------------------------------
    localparam logic [16:0] UNLOCK_ADDR1 = 17'h0_5555;
    localparam logic [16:0] UNLOCK_ADDR2 = 17'h0_2AAA;
    localparam logic [7:0]  UNLOCK_DATA1 = 8'hAA;
    localparam logic [7:0]  UNLOCK_DATA2 = 8'h55;
    localparam logic [7:0]  CODE_RESET   = 8'hF0;
    localparam logic [7:0]  CODE_PROG    = 8'hA0;
    localparam logic [7:0]  CODE_ESETUP  = 8'h80;
    localparam logic [7:0]  CODE_CHIP    = 8'h10;
    localparam logic [7:0]  CODE_SECT    = 8'h30;

    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0] STROBE_CYC_RST = 8'h14; // 21-cycle, 84 ns strobes
    localparam int CLK_MHZ        = 250;
    localparam int WINDOW_US      = 50;
    localparam int WINDOW_CYC     = WINDOW_US * CLK_MHZ; // 12500, longest time
    localparam int SYNC_STAGES    = 2;

    // flash pin bundle driven by the host
    typedef struct packed {
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic [16:0] addr;
        logic [7:0]  dout;
        logic        doe;   // high while host drives data_lines
    } fws_pins_t;

    // apb slave response bundle
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } fws_apb_rsp_t;

endpackage

// >>> core/fws_bus_cycle.sv
// module: one flash read or write strobe cycle on the parallel pins
`timescale 1ns/100ps

module fws_bus_cycle (
    // clock and reset
    input  wire logic                core_clk_i,
    input  wire logic                reset_n_i,
    // request
    input  wire logic                start_i,
    input  wire logic                write_i,
    input  wire logic [16:0]         addr_i,
    input  wire logic [7:0]          wdata_i,
    input  wire logic [7:0]          width_i,
    // answer
    output logic                     done_o,
    output logic [7:0]               rdata_o,
    // flash pins
    output fws_pkg::fws_pins_t       pins_o,
    input  wire logic [7:0]          data_lines_i
);

    typedef enum logic [1:0] {BC_IDLE, BC_STROBE, BC_RECOVER} fws_bc_st_t;

    typedef struct packed {
        fws_bc_st_t         st;
        logic [7:0]         cnt;
        logic               wr;
        logic               done;
        logic [7:0]         rdata;
        logic [7:0]         sync1;
        logic [7:0]         sync2;
        fws_pkg::fws_pins_t pins;
    } fws_bc_t;

    fws_bc_t s_q;
    fws_bc_t s_d;

    // strobe sequencing; data sampled through two flops before use
    always_comb begin
        s_d       = s_q;
        s_d.done  = 1'b0;
        s_d.sync1 = data_lines_i;
        s_d.sync2 = s_q.sync1;
        case (s_q.st)
            BC_IDLE: begin
                if (start_i) begin
                    s_d.st        = BC_STROBE;
                    s_d.cnt       = width_i;
                    s_d.wr        = write_i;
                    s_d.pins.addr = addr_i;
                    s_d.pins.dout = wdata_i;
                    s_d.pins.doe  = write_i;
                    s_d.pins.ce_n = 1'b0;
                    s_d.pins.oe_n = write_i;
                    s_d.pins.we_n = ~write_i;
                end
            end
            BC_STROBE: begin
                if (s_q.cnt == 8'h00) begin
                    // strobe rises: ends the cycle for the device
                    s_d.st        = BC_RECOVER;
                    s_d.cnt       = width_i;
                    s_d.pins.ce_n = 1'b1;
                    s_d.pins.oe_n = 1'b1;
                    s_d.pins.we_n = 1'b1;
                    s_d.rdata     = s_q.sync2;
                end else begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end
            end
            BC_RECOVER: begin
                if (s_q.cnt == 8'h00) begin
                    s_d.st       = BC_IDLE;
                    s_d.pins.doe = 1'b0;
                    s_d.done     = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end
            end
            default: s_d.st = BC_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_q           <= '0;
            s_q.st        <= BC_IDLE;
            s_q.pins.ce_n <= 1'b1;
            s_q.pins.oe_n <= 1'b1;
            s_q.pins.we_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign done_o  = s_q.done;
    assign rdata_o = s_q.rdata;
    assign pins_o  = s_q.pins;

endmodule

// >>> tb/fws_host_sva.sv
// checker: apb answer and flash strobe timing of the host
`timescale 1ns/100ps
module fws_host_sva (
    // clock and reset
    input  wire logic                  core_clk_i,
    input  wire logic                  reset_n_i,
    // apb
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic [7:0]            paddr_i,
    input  wire fws_pkg::fws_apb_rsp_t apb_o,
    // flash pins
    input  wire fws_pkg::fws_pins_t    flash_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    // offsets that hold a register
    logic map_w;
    assign map_w = paddr_i <= 8'h10 && paddr_i[1:0] == 2'h0;
    property p_ans; psel_i && penable_i && !apb_o.pready |=> apb_o.pready; endproperty
    property p_pulse; apb_o.pready |=> !apb_o.pready; endproperty
    property p_err; apb_o.pready && !map_w |-> apb_o.pslverr && apb_o.prdata == 32'h0; endproperty
    property p_rd; !flash_o.oe_n && $past(!flash_o.oe_n) |-> $stable(flash_o.addr); endproperty
    property p_wr;
        !flash_o.we_n && $past(!flash_o.we_n) |-> $stable({flash_o.addr, flash_o.dout}) && flash_o.doe;
    endproperty
    property p_clash; !flash_o.oe_n |-> !flash_o.doe && !flash_o.ce_n && flash_o.we_n; endproperty
    property p_wlen; $fell(flash_o.we_n) |-> !flash_o.we_n [*8]; endproperty
    property p_rlen; $fell(flash_o.oe_n) |-> !flash_o.oe_n [*8]; endproperty
    a_ans: assert property (p_ans) else $error("pready late");
    a_pulse: assert property (p_pulse) else $error("pready too long");
    a_err: assert property (p_err) else $error("unmapped answer wrong");
    a_rd: assert property (p_rd) else $error("read address moved");
    a_wr: assert property (p_wr) else $error("write cycle moved");
    a_clash: assert property (p_clash) else $error("read with data driven");
    a_wlen: assert property (p_wlen) else $error("write strobe short");
    a_rlen: assert property (p_rlen) else $error("read strobe short");
    c_err: cover property (apb_o.pready && apb_o.pslverr);
    c_wr: cover property ($fell(flash_o.we_n));
    c_rd: cover property ($fell(flash_o.oe_n));
endmodule
bind fws_host fws_host_sva chk_u (.core_clk_i, .reset_n_i, .psel_i, .penable_i, .paddr_i,
                                  .apb_o, .flash_o);

// >>> tb/fws_flash_model.sv
// model: flash device status bits as seen by the host
`timescale 1ns/100ps
module fws_flash_model (
    // clock and pins
    input  wire logic               core_clk_i,
    input  wire fws_pkg::fws_pins_t pins_i,
    // busy length and failure knobs
    input  wire logic [3:0]         reads_i,
    input  wire logic               fail_i,
    // data lines back
    output logic [7:0]              data_o,
    output logic                    busy_o
);
    logic [7:0] pd_q, last_q;
    logic       we_q, oe_q, tog_q, lim_q, ers_q, arm_q;
    logic [3:0] left_q;
    // strobe history starts at the idle high level: no false edge after reset
    initial {pd_q, last_q, tog_q, lim_q, ers_q, arm_q, left_q, busy_o, we_q, oe_q} = {25'h0, 2'b11};
    // busy from last strobe, reset clears
    always @(posedge core_clk_i) begin
        we_q <= pins_i.we_n;
        oe_q <= pins_i.oe_n;
        if (!pins_i.oe_n && !pins_i.ce_n) last_q <= data_o;
        if (pins_i.we_n && !we_q) begin
            arm_q <= !arm_q && pins_i.dout == fws_pkg::CODE_PROG;
            if (arm_q || pins_i.dout inside {fws_pkg::CODE_CHIP, fws_pkg::CODE_SECT}) begin
                busy_o <= 1;
                left_q <= reads_i;
                lim_q <= 0;
                ers_q <= !arm_q;
            end
            if (arm_q) pd_q <= pins_i.dout;
            if (!arm_q && pins_i.dout == fws_pkg::CODE_RESET) {busy_o, lim_q} <= 2'b00;
        end
        // toggle inverts after each busy read
        if (pins_i.oe_n && !oe_q && busy_o) begin
            tog_q <= !tog_q;
            left_q <= left_q - 4'h1;
            lim_q <= fail_i;
            if (left_q <= 4'h1 && !fail_i) busy_o <= 0;
        end
    end
    // bit 3 high: window expired, erase running
    // status while busy, idle lines inverted
    always_comb begin
        if (pins_i.oe_n || pins_i.ce_n) data_o = ~last_q;
        else if (busy_o) data_o = {!ers_q && !pd_q[7], tog_q, lim_q, 1'b0, ers_q, 3'h5};
        else data_o = ers_q ? 8'hFF : pd_q;
    end
endmodule

// >>> tb/fws_host_test.sv
// bench: apb driven host against the flash model, self checking
`timescale 1ns/100ps
module fws_host_test;
    logic                  core_clk_i, reset_n_i, psel_i, penable_i, pwrite_i, fail_q, busy_w;
    logic                  err_q;
    logic [7:0]            paddr_i, dl_w, d;
    logic [31:0]           pwdata_i, rd_q;
    logic [3:0]            reads_q;
    fws_pkg::fws_apb_rsp_t apb_o;
    fws_pkg::fws_pins_t    flash_o;
    int                    bad_count, checks_done, cyc;
    fws_host dut_u (.core_clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
                    .pwdata_i, .apb_o, .flash_o, .data_lines_i(dl_w));
    fws_flash_model m_u (.core_clk_i, .pins_i(flash_o), .reads_i(reads_q), .fail_i(fail_q),
                         .data_o(dl_w), .busy_o(busy_w));
    // clock and hang guard
    initial begin
        core_clk_i = 0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            bad_count++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel_i <= 1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge core_clk_i);
        penable_i <= 1;
        do @(posedge core_clk_i); while (apb_o.pready !== 1'b1);
        rd_q = apb_o.prdata;
        err_q = apb_o.pslverr;
        psel_i <= 0;
        penable_i <= 0;
        @(posedge core_clk_i);
    endtask
    // start a command, refuse a timing write while busy, poll until idle
    task automatic op(input logic [2:0] c, input logic [7:0] wd, input logic f, input logic cd,
                      input logic [7:0] ed);
        int n;
        n = 0;
        reads_q <= 4'($urandom_range(1, 6));
        fail_q <= f;
        apb(1, fws_pkg::REG_ADDR, {15'h0, 17'($urandom)});
        apb(1, fws_pkg::REG_DATA, {24'h0, wd});
        apb(1, fws_pkg::REG_CTRL, {29'h0, c});
        apb(1, fws_pkg::REG_TIMING, 32'h0000_0003);
        do begin
            apb(0, fws_pkg::REG_STATUS, 32'h0);
            n++;
        end while (rd_q[0] !== 1'b0 && n < 3000);
        chk("busy", {31'h0, rd_q[0]}, 32'h0);
        chk("fail", {31'h0, rd_q[2]}, {31'h0, f});
        chk("flash idle", {31'h0, busy_w}, 32'h0);
        apb(0, fws_pkg::REG_DATA, 32'h0);
        if (cd) chk("data", rd_q, {24'h0, ed});
        apb(0, fws_pkg::REG_TIMING, 32'h0);
        chk("timing", rd_q, {24'h0, fws_pkg::STROBE_CYC_RST});
    endtask
    initial begin
        {psel_i, penable_i, pwrite_i, fail_q, reset_n_i} = '0;
        {paddr_i, pwdata_i, reads_q, bad_count, checks_done, cyc} = '0;
        void'($urandom(32'h2444_61a5));
        repeat (20) @(posedge core_clk_i);
        reset_n_i <= 1;
        @(posedge core_clk_i);
        apb(0, 8'h20, 32'h0);
        chk("unmapped", {err_q, rd_q[30:0]}, 32'h8000_0000);
        for (int i = 0; i < 3; i++) begin
            d = 8'($urandom);
            op(fws_pkg::CMD_PROG, d, 0, 1, d);
        end
        op(fws_pkg::CMD_READ, 8'h00, 0, 1, d);
        op(fws_pkg::CMD_CHIP, 8'h00, 0, 1, 8'hFF);
        op(fws_pkg::CMD_SECT, 8'h00, 0, 1, 8'hFF);
        // erase over: window bit reads high, added sector must be dropped
        op(fws_pkg::CMD_ADDSEC, 8'h00, 0, 0, 8'h00);
        apb(0, fws_pkg::REG_STATUS, 32'h0);
        chk("window drop", {27'h0, rd_q[4:3], 3'h0}, 32'h0000_0018);
        op(fws_pkg::CMD_PROG, 8'h5A, 1, 0, 8'h00);
        op(fws_pkg::CMD_RESET, 8'h00, 0, 0, 8'h00);
        conclude();
    end
endmodule
